// File: src/pmc_pkg.sv
package pmc_pkg;

    // operating states of the power mode controller
    typedef enum logic [2:0] {
        PMC_RUN,
        PMC_DEEP_SLEEP,
        PMC_SLEEP_LOW_CLOCK,
        PMC_IDLE_CLOCK_OFF,
        PMC_IDLE_CLOCK_ON,
        PMC_WAKE
    } pmc_state_t;

    // system clock source actually gated through to the core
    typedef enum logic [1:0] {
        PMC_SRC_NONE,
        PMC_SRC_HIGH,
        PMC_SRC_LOW
    } pmc_src_t;

    // width of the oscillator tick counters
    localparam int unsigned PMC_CNT_W          = 10;

    // stabilisation counts, in ticks of the oscillator concerned
    localparam int unsigned PMC_HXT_STAB_TICKS  = 128;
    localparam int unsigned PMC_INTERNAL_HIGH_RC_STAB_TICKS = 16;
    localparam int unsigned PMC_LXT_STAB_TICKS  = 128;
    localparam int unsigned PMC_INTERNAL_LOW_RC_STAB_TICKS = 2;

    // low speed ticks before the core resumes on a fast wake-up
    localparam int unsigned PMC_FAST_WAKE_TICKS = 2;

    // dead gap count between two sources; no source is selected for one cycle more than this
    localparam int unsigned PMC_SWITCH_GAP_CYC  = 2;

    // divider codes: 000 and 001 pick the low speed clock
    localparam logic [2:0]  PMC_DIV_LOW_MAX     = 3'h1;

    // bit positions in the system mode register view
    localparam int unsigned PMC_BIT_HIGH_SEL    = 0;
    localparam int unsigned PMC_BIT_IDLE_HALT   = 1;
    localparam int unsigned PMC_BIT_HIGH_RDY    = 2;
    localparam int unsigned PMC_BIT_LOW_RDY     = 3;
    localparam int unsigned PMC_BIT_FAST_WAKE   = 4;
    localparam int unsigned PMC_BIT_DIV_LSB     = 5;

    // values after reset
    localparam logic [2:0]  PMC_DIV_RESET       = 3'h0;

endpackage : pmc_pkg

// File: src/pmc_clock_switch.sv
`timescale 1ns/1ns
// Notes on behaviour
// - fast wake runs core on low clock until high oscillator is stable.
// - fast wake ignored from deep sleep; low oscillators are off there.
// - crystal fast wake resumes after low ticks, switches after stab count.
// - rc oscillators wake after their own short counts; fast wake unused.
// - halt picks idle or sleep; run clock follows select and divider.
// - low clock selected stops high oscillator and its divided clocks.
// - switch to low clock completes after low_osc_ready; software watches it.
// - back to full speed via select or divider; software polls ready.
// - deep sleep only on halt, idle off, watchdog and detector off.
// - deep sleep stops system and time base; watchdog cleared, halted.
// - halt with idle off and watchdog on enters sleep with watchdog on low clock.
// - halt with idle on, keep off enters idle with system clock off.
// - sleep_low or idle_off entry clears watchdog, keeps it counting.
// - any halt entry stops core, sets power down, clears timeout flag.
// - halt with idle and keep both set leaves clocks running.
// - wake on enabled pin falling edge, interrupt or watchdog overflow.
// - fast wake enable sits at bit 4 of the mode register view.
module pmc_clock_switch
    import pmc_pkg::*;
#(
    parameter int unsigned HXT_STAB_TICKS  = PMC_HXT_STAB_TICKS,
    parameter int unsigned INTERNAL_HIGH_RC_STAB_TICKS = PMC_INTERNAL_HIGH_RC_STAB_TICKS,
    parameter int unsigned LXT_STAB_TICKS  = PMC_LXT_STAB_TICKS,
    parameter int unsigned INTERNAL_LOW_RC_STAB_TICKS = PMC_INTERNAL_LOW_RC_STAB_TICKS
)(
    input  wire logic       MCLK,
    input  wire logic       RST_B,
    input  wire logic       HALT,
    input  wire logic       HIGH_CLOCK_SELECT,
    input  wire logic [2:0] CLOCK_DIVIDER_SELECT,
    input  wire logic       FAST_WAKE_ENABLE,
    input  wire logic       IDLE_ON_HALT,
    input  wire logic       SYSCLK_KEEP_IN_IDLE,
    input  wire logic       WDT_ENABLE,
    input  wire logic       LVD_ENABLE,
    input  wire logic       HIGH_OSC_IS_XTAL,
    input  wire logic       LOW_OSC_IS_XTAL,
    input  wire logic       HIGH_OSC_TICK,
    input  wire logic       LOW_OSC_TICK,
    input  wire logic       WAKE_PIN_FALL,
    input  wire logic       WAKE_IRQ,
    input  wire logic       WDT_OVERFLOW,
    input  wire logic       CLEAR_WDT_CMD,
    output logic            HIGH_OSC_ON,
    output logic            LOW_OSC_ON,
    output logic            SYSCLK_SEL_HIGH,
    output logic            SYSCLK_SEL_LOW,
    output logic [2:0]      SYSCLK_DIV,
    output logic            DIV_CLKS_ON,
    output logic            TIMEBASE_CLK_ON,
    output logic            CPU_RUN,
    output logic            WDT_RUN,
    output logic            WDT_CLEAR,
    output logic            HIGH_OSC_READY,
    output logic            LOW_OSC_READY,
    output logic            POWER_DOWN_FLAG,
    output logic            WATCHDOG_TIMEOUT_FLAG,
    output logic [7:0]      SYSTEM_MODE_VIEW
);

    // refuse counts the tick counters cannot hold
    if (HXT_STAB_TICKS < 1 || HXT_STAB_TICKS >= (1 << PMC_CNT_W) ||
        INTERNAL_HIGH_RC_STAB_TICKS < 1 || INTERNAL_HIGH_RC_STAB_TICKS >= (1 << PMC_CNT_W) ||
        LXT_STAB_TICKS < 1 || LXT_STAB_TICKS >= (1 << PMC_CNT_W) ||
        INTERNAL_LOW_RC_STAB_TICKS < 1 || INTERNAL_LOW_RC_STAB_TICKS >= (1 << PMC_CNT_W))
    begin : g_bad_count
        $error("stabilisation count out of range");
    end

    localparam logic [PMC_CNT_W-1:0] HXT_LIM  =
        PMC_CNT_W'(HXT_STAB_TICKS);
    localparam logic [PMC_CNT_W-1:0] INTERNAL_HIGH_RC_LIM =
        PMC_CNT_W'(INTERNAL_HIGH_RC_STAB_TICKS);
    localparam logic [PMC_CNT_W-1:0] LXT_LIM  =
        PMC_CNT_W'(LXT_STAB_TICKS);
    localparam logic [PMC_CNT_W-1:0] INTERNAL_LOW_RC_LIM =
        PMC_CNT_W'(INTERNAL_LOW_RC_STAB_TICKS);
    localparam logic [PMC_CNT_W-1:0] FAST_LIM =
        PMC_CNT_W'(PMC_FAST_WAKE_TICKS);
    localparam logic [1:0]           GAP_LIM  =
        2'(PMC_SWITCH_GAP_CYC);

    pmc_state_t           state_r,    state_nxt;
    logic                 fast_ok_r,  fast_ok_nxt;
    logic                 handover_r, handover_nxt;
    logic [PMC_CNT_W-1:0] wake_cnt_r, wake_cnt_nxt;
    logic                 pdf_r,      pdf_nxt;
    logic                 tof_r,      tof_nxt;
    logic                 wclr_r,     wclr_nxt;
    logic [PMC_CNT_W-1:0] hi_cnt_r,   hi_cnt_nxt;
    logic                 hi_rdy_r,   hi_rdy_nxt;
    logic [PMC_CNT_W-1:0] lo_cnt_r,   lo_cnt_nxt;
    logic                 lo_rdy_r,   lo_rdy_nxt;
    pmc_src_t             src_r,      src_nxt;
    logic [1:0]           gap_r,      gap_nxt;
    logic [2:0]           div_r,      div_nxt;

    logic                 cfg_low;
    logic                 tgt_low;
    logic                 sys_want;
    logic                 hi_en;
    logic                 lo_en;
    logic                 wake_evt;
    logic                 fast_path;
    logic [PMC_CNT_W-1:0] hi_lim;
    logic [PMC_CNT_W-1:0] lo_lim;

    // decode of the run clock choice and oscillator needs
    always_comb
    begin
        cfg_low  = !HIGH_CLOCK_SELECT &&
                   (CLOCK_DIVIDER_SELECT <= PMC_DIV_LOW_MAX);
        tgt_low  = cfg_low || handover_r;
        sys_want = (state_r == PMC_RUN) ||
                   (state_r == PMC_IDLE_CLOCK_ON);
        // high oscillator stops once the high source has been dropped for the low clock
        hi_en    = (sys_want || state_r == PMC_WAKE) &&
                   (!cfg_low || src_r == PMC_SRC_HIGH);
        lo_en    = (state_r != PMC_DEEP_SLEEP);
        wake_evt = WAKE_PIN_FALL || WAKE_IRQ || WDT_OVERFLOW;
        fast_path = fast_ok_r && FAST_WAKE_ENABLE && HIGH_OSC_IS_XTAL &&
                    !cfg_low;
        hi_lim   = HIGH_OSC_IS_XTAL ? HXT_LIM : INTERNAL_HIGH_RC_LIM;
        lo_lim   = LOW_OSC_IS_XTAL ? LXT_LIM : INTERNAL_LOW_RC_LIM;
    end

    // operating mode, wake sequencing and status flags
    always_comb
    begin
        state_nxt    = state_r;
        fast_ok_nxt  = fast_ok_r;
        handover_nxt = handover_r;
        wake_cnt_nxt = '0;
        pdf_nxt      = pdf_r;
        tof_nxt      = tof_r;
        wclr_nxt     = 1'b0;
        // software clears the flags; hardware events below win
        if (CLEAR_WDT_CMD)
        begin
            pdf_nxt = 1'b0;
            tof_nxt = 1'b0;
        end
        if (WDT_OVERFLOW && WDT_ENABLE && state_r != PMC_DEEP_SLEEP)
        begin
            tof_nxt = 1'b1;
        end
        // handover ends as soon as the crystal is stable
        if (handover_r && hi_rdy_r)
        begin
            handover_nxt = 1'b0;
        end
        case (state_r)
            PMC_RUN:
            begin
                if (HALT)
                begin
                    pdf_nxt     = 1'b1;
                    tof_nxt     = 1'b0;
                    wclr_nxt    = 1'b1;
                    fast_ok_nxt = 1'b0;
                    if (IDLE_ON_HALT && SYSCLK_KEEP_IN_IDLE)
                    begin
                        state_nxt = PMC_IDLE_CLOCK_ON;
                    end
                    else if (IDLE_ON_HALT)
                    begin
                        state_nxt   = PMC_IDLE_CLOCK_OFF;
                        fast_ok_nxt = 1'b1;
                    end
                    else if (!WDT_ENABLE && !LVD_ENABLE)
                    begin
                        state_nxt = PMC_DEEP_SLEEP;
                    end
                    else
                    begin
                        state_nxt   = PMC_SLEEP_LOW_CLOCK;
                        fast_ok_nxt = 1'b1;
                    end
                end
            end
            PMC_IDLE_CLOCK_ON:
            begin
                if (wake_evt)
                begin
                    state_nxt = PMC_RUN;
                end
            end
            PMC_DEEP_SLEEP,
            PMC_SLEEP_LOW_CLOCK,
            PMC_IDLE_CLOCK_OFF:
            begin
                if (wake_evt)
                begin
                    state_nxt = PMC_WAKE;
                end
            end
            PMC_WAKE:
            begin
                wake_cnt_nxt = wake_cnt_r;
                if (fast_path && lo_rdy_r)
                begin
                    // resume on the low clock after a few of its ticks
                    if (LOW_OSC_TICK)
                    begin
                        wake_cnt_nxt = wake_cnt_r + 1'b1;
                    end
                    if (LOW_OSC_TICK && wake_cnt_r + 1'b1 == FAST_LIM)
                    begin
                        state_nxt    = PMC_RUN;
                        handover_nxt = !hi_rdy_r;
                    end
                end
                else if (cfg_low ? lo_rdy_r : hi_rdy_r)
                begin
                    state_nxt = PMC_RUN;
                end
            end
            default:
            begin
                state_nxt = PMC_RUN;
            end
        endcase
    end

    // oscillator stability counters and glitch free source switch
    always_comb
    begin
        hi_cnt_nxt = hi_cnt_r;
        hi_rdy_nxt = hi_rdy_r;
        lo_cnt_nxt = lo_cnt_r;
        lo_rdy_nxt = lo_rdy_r;
        src_nxt    = src_r;
        gap_nxt    = gap_r;
        div_nxt    = div_r;
        // ready drops whenever the oscillator is stopped
        if (!hi_en)
        begin
            hi_cnt_nxt = '0;
            hi_rdy_nxt = 1'b0;
        end
        else if (!hi_rdy_r && HIGH_OSC_TICK)
        begin
            hi_cnt_nxt = hi_cnt_r + 1'b1;
            hi_rdy_nxt = (hi_cnt_r + 1'b1 == hi_lim);
        end
        if (!lo_en)
        begin
            lo_cnt_nxt = '0;
            lo_rdy_nxt = 1'b0;
        end
        else if (!lo_rdy_r && LOW_OSC_TICK)
        begin
            lo_cnt_nxt = lo_cnt_r + 1'b1;
            lo_rdy_nxt = (lo_cnt_r + 1'b1 == lo_lim);
        end
        // break before make: drop the old source, wait, take the new
        if (gap_r != 2'h0)
        begin
            gap_nxt = gap_r - 2'h1;
        end
        if (!sys_want)
        begin
            if (src_r != PMC_SRC_NONE)
            begin
                src_nxt = PMC_SRC_NONE;
                gap_nxt = GAP_LIM;
            end
        end
        else if (src_r == PMC_SRC_NONE)
        begin
            if (gap_r == 2'h0 && tgt_low && lo_rdy_r)
            begin
                src_nxt = PMC_SRC_LOW;
            end
            else if (gap_r == 2'h0 && !tgt_low && hi_rdy_r)
            begin
                src_nxt = PMC_SRC_HIGH;
                div_nxt = HIGH_CLOCK_SELECT ? PMC_DIV_RESET
                                            : CLOCK_DIVIDER_SELECT;
            end
        end
        else if ((src_r == PMC_SRC_HIGH && tgt_low && lo_rdy_r) ||
                 (src_r == PMC_SRC_LOW && !tgt_low && hi_rdy_r))
        begin
            src_nxt = PMC_SRC_NONE;
            gap_nxt = GAP_LIM;
        end
        else if (src_r == PMC_SRC_HIGH &&
                 div_r != (HIGH_CLOCK_SELECT ? PMC_DIV_RESET
                                             : CLOCK_DIVIDER_SELECT))
        begin
            // divider change also passes through the dead gap
            src_nxt = PMC_SRC_NONE;
            gap_nxt = GAP_LIM;
        end
    end

    // state registers
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state_r    <= PMC_RUN;
            fast_ok_r  <= 1'b0;
            handover_r <= 1'b0;
            wake_cnt_r <= '0;
            pdf_r      <= 1'b0;
            tof_r      <= 1'b0;
            wclr_r     <= 1'b0;
            hi_cnt_r   <= '0;
            hi_rdy_r   <= 1'b0;
            lo_cnt_r   <= '0;
            lo_rdy_r   <= 1'b0;
            src_r      <= PMC_SRC_NONE;
            gap_r      <= 2'h0;
            div_r      <= PMC_DIV_RESET;
        end
        else
        begin
            state_r    <= state_nxt;
            fast_ok_r  <= fast_ok_nxt;
            handover_r <= handover_nxt;
            wake_cnt_r <= wake_cnt_nxt;
            pdf_r      <= pdf_nxt;
            tof_r      <= tof_nxt;
            wclr_r     <= wclr_nxt;
            hi_cnt_r   <= hi_cnt_nxt;
            hi_rdy_r   <= hi_rdy_nxt;
            lo_cnt_r   <= lo_cnt_nxt;
            lo_rdy_r   <= lo_rdy_nxt;
            src_r      <= src_nxt;
            gap_r      <= gap_nxt;
            div_r      <= div_nxt;
        end
    end

    // outputs to oscillators, clock gates and the core
    assign HIGH_OSC_ON     = hi_en;
    assign LOW_OSC_ON      = lo_en;
    assign SYSCLK_SEL_HIGH = (src_r == PMC_SRC_HIGH);
    assign SYSCLK_SEL_LOW  = (src_r == PMC_SRC_LOW);
    assign SYSCLK_DIV      = div_r;
    assign DIV_CLKS_ON     = hi_rdy_r;
    assign TIMEBASE_CLK_ON = (state_r != PMC_DEEP_SLEEP) &&
                             (state_r != PMC_SLEEP_LOW_CLOCK);
    assign CPU_RUN         = (state_r == PMC_RUN);
    assign WDT_RUN         = WDT_ENABLE &&
                             (state_r != PMC_DEEP_SLEEP);
    assign WDT_CLEAR       = wclr_r;
    assign HIGH_OSC_READY  = hi_rdy_r;
    assign LOW_OSC_READY   = lo_rdy_r;
    assign POWER_DOWN_FLAG = pdf_r;
    assign WATCHDOG_TIMEOUT_FLAG = tof_r;

    // read view of the mode bits in their register positions
    always_comb
    begin
        SYSTEM_MODE_VIEW = 8'h00;
        SYSTEM_MODE_VIEW[PMC_BIT_HIGH_SEL]  = HIGH_CLOCK_SELECT;
        SYSTEM_MODE_VIEW[PMC_BIT_IDLE_HALT] = IDLE_ON_HALT;
        SYSTEM_MODE_VIEW[PMC_BIT_HIGH_RDY]  = hi_rdy_r;
        SYSTEM_MODE_VIEW[PMC_BIT_LOW_RDY]   = lo_rdy_r;
        SYSTEM_MODE_VIEW[PMC_BIT_FAST_WAKE] = FAST_WAKE_ENABLE;
        SYSTEM_MODE_VIEW[PMC_BIT_DIV_LSB +: 3] = CLOCK_DIVIDER_SELECT;
    end

endmodule // pmc_clock_switch

// File: tb/pmc_clock_switch_properties.sv
`timescale 1ns/1ns
module pmc_clock_switch_properties
    import pmc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic HALT,
    input wire logic IDLE_ON_HALT,
    input wire logic SYSCLK_KEEP_IN_IDLE,
    input wire logic WDT_ENABLE,
    input wire logic LVD_ENABLE,
    input wire logic WDT_OVERFLOW,
    input wire logic CLEAR_WDT_CMD,
    input wire logic HIGH_OSC_ON,
    input wire logic LOW_OSC_ON,
    input wire logic SYSCLK_SEL_HIGH,
    input wire logic SYSCLK_SEL_LOW,
    input wire logic DIV_CLKS_ON,
    input wire logic TIMEBASE_CLK_ON,
    input wire logic CPU_RUN,
    input wire logic WDT_RUN,
    input wire logic WDT_CLEAR,
    input wire logic HIGH_OSC_READY,
    input wire logic LOW_OSC_READY,
    input wire logic POWER_DOWN_FLAG,
    input wire logic WATCHDOG_TIMEOUT_FLAG
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_B);
    // a halt accepted while the core runs
    sequence s_halt_taken;
        HALT && CPU_RUN;
    endsequence
    // both gates shut during the cycle after the state change
    sequence s_src_none;
        ##1 (!SYSCLK_SEL_HIGH && !SYSCLK_SEL_LOW);
    endsequence
    AST_SEL_EXCLUSIVE: assert property (
        !(SYSCLK_SEL_HIGH && SYSCLK_SEL_LOW))
        else $error("both clock sources gated on");
    AST_HIGH_GAP: assert property (
        $fell(SYSCLK_SEL_HIGH) |-> !SYSCLK_SEL_LOW[*2])
        else $error("low source gated without dead gap");
    AST_LOW_GAP: assert property (
        $fell(SYSCLK_SEL_LOW) |-> !SYSCLK_SEL_HIGH[*2])
        else $error("high source gated without dead gap");
    AST_HALT_ENTRY: assert property (
        s_halt_taken |=> (!CPU_RUN && POWER_DOWN_FLAG && WDT_CLEAR
        && !WATCHDOG_TIMEOUT_FLAG) ##1 !WDT_CLEAR)
        else $error("halt entry flags wrong");
    AST_DEEP_SLEEP: assert property (
        s_halt_taken and (!IDLE_ON_HALT && !WDT_ENABLE && !LVD_ENABLE)
        |=> !LOW_OSC_ON && !WDT_RUN && !TIMEBASE_CLK_ON)
        else $error("deep sleep clocks still on");
    AST_SLEEP_LOW: assert property (
        s_halt_taken and (!IDLE_ON_HALT && (WDT_ENABLE || LVD_ENABLE))
        |=> (LOW_OSC_ON && !TIMEBASE_CLK_ON && WDT_RUN == WDT_ENABLE)
        ##0 s_src_none)
        else $error("sleep with low clock entered wrongly");
    AST_IDLE_OFF: assert property (
        s_halt_taken and (IDLE_ON_HALT && !SYSCLK_KEEP_IN_IDLE)
        |=> (TIMEBASE_CLK_ON && LOW_OSC_ON) ##0 s_src_none)
        else $error("idle with clock off entered wrongly");
    AST_IDLE_ON: assert property (
        s_halt_taken and (IDLE_ON_HALT && SYSCLK_KEEP_IN_IDLE)
        |=> TIMEBASE_CLK_ON && LOW_OSC_ON && ($stable(SYSCLK_SEL_HIGH)
        && $stable(SYSCLK_SEL_LOW))[*2])
        else $error("idle with clock on lost a clock");
    AST_HIGH_RDY_OFF: assert property (
        !HIGH_OSC_ON |=> !HIGH_OSC_READY)
        else $error("high ready while oscillator stopped");
    AST_DIV_CLKS_OFF: assert property (
        !HIGH_OSC_ON[*2] |=> !DIV_CLKS_ON)
        else $error("divided clocks run with oscillator stopped");
    AST_LOW_SEL_READY: assert property (
        $rose(SYSCLK_SEL_LOW) |-> LOW_OSC_READY)
        else $error("low source gated before ready");
    AST_HIGH_SEL_READY: assert property (
        $rose(SYSCLK_SEL_HIGH) |-> HIGH_OSC_READY)
        else $error("high source gated before ready");
    AST_HALT_REFUSED: assert property (
        HALT && !CPU_RUN |=> !WDT_CLEAR)
        else $error("halt taken while stopped");
    AST_FLAG_CLEAR: assert property (
        CLEAR_WDT_CMD && !HALT && !WDT_OVERFLOW
        |=> !POWER_DOWN_FLAG && !WATCHDOG_TIMEOUT_FLAG)
        else $error("clear command left a flag set");
endmodule // pmc_clock_switch_properties

bind pmc_clock_switch pmc_clock_switch_properties u_props (
    .MCLK(MCLK), .RST_B(RST_B), .HALT(HALT), .IDLE_ON_HALT(IDLE_ON_HALT),
    .SYSCLK_KEEP_IN_IDLE(SYSCLK_KEEP_IN_IDLE), .WDT_ENABLE(WDT_ENABLE),
    .LVD_ENABLE(LVD_ENABLE), .WDT_OVERFLOW(WDT_OVERFLOW),
    .CLEAR_WDT_CMD(CLEAR_WDT_CMD), .HIGH_OSC_ON(HIGH_OSC_ON),
    .LOW_OSC_ON(LOW_OSC_ON), .SYSCLK_SEL_HIGH(SYSCLK_SEL_HIGH),
    .SYSCLK_SEL_LOW(SYSCLK_SEL_LOW), .DIV_CLKS_ON(DIV_CLKS_ON),
    .TIMEBASE_CLK_ON(TIMEBASE_CLK_ON), .CPU_RUN(CPU_RUN), .WDT_RUN(WDT_RUN),
    .WDT_CLEAR(WDT_CLEAR), .HIGH_OSC_READY(HIGH_OSC_READY),
    .LOW_OSC_READY(LOW_OSC_READY), .POWER_DOWN_FLAG(POWER_DOWN_FLAG),
    .WATCHDOG_TIMEOUT_FLAG(WATCHDOG_TIMEOUT_FLAG)
);

// File: tb/pmc_osc_model.sv
`timescale 1ns/1ns
module pmc_osc_model
#(
    parameter int unsigned HIGH_PER = 7,
    parameter int unsigned LOW_PER  = 3
)(
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic slow,
    input  wire logic high_on,
    input  wire logic low_on,
    output logic      high_tick,
    output logic      low_tick
);
    int unsigned high_cnt_r;
    int unsigned low_cnt_r;
    // period counters restart whenever an oscillator is stopped
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            high_cnt_r <= 0;
            low_cnt_r  <= 0;
        end
        else
        begin
            high_cnt_r <= (!high_on || high_tick) ? 0 : high_cnt_r + 1;
            low_cnt_r  <= (!low_on || low_tick) ? 0 : low_cnt_r + 1;
        end
    end
    // a stopped oscillator gives no ticks; slow start of the high oscillator is four times longer
    assign high_tick = high_on
        && (high_cnt_r == (slow ? 4 * HIGH_PER : HIGH_PER) - 1);
    assign low_tick  = low_on && (low_cnt_r == LOW_PER - 1);
endmodule // pmc_osc_model

// File: tb/pmc_clock_switch_tb_top.sv
`timescale 1ns/1ns
module pmc_clock_switch_tb_top
    import pmc_pkg::*;
;
    logic       mclk, rst_b, halt, high_sel, fast_wake, idle_halt, keep_clk;
    logic       wdt_en, lvd_en, high_xtal, low_xtal, high_tick, low_tick;
    logic       pin_fall, irq, wdt_ovf, clr_wdt, slow, high_on, low_on;
    logic       sel_high, sel_low, div_clks, tb_clk, cpu_run, wdt_run;
    logic       wdt_clr, high_rdy, low_rdy, pd_flag, wdt_flag;
    logic [2:0] div_sel, sysclk_div;
    logic [7:0] mode_view;
    logic [7:0] halt_q[$];
    logic       wake_q[$];
    logic [2:0] div_q[$];
    int         error_cnt = 0;
    int         n_compared = 0;
    // scenario table: idle, keep, wdt, lvd, fast, xtal, ready at resume
    localparam logic [6:0] SCN [7] = '{7'h77, 7'h56, 7'h16, 7'h07,
                                       7'h0B, 7'h15, 7'h53};

    pmc_clock_switch #(
        .HXT_STAB_TICKS(4), .INTERNAL_HIGH_RC_STAB_TICKS(4),
        .LXT_STAB_TICKS(4), .INTERNAL_LOW_RC_STAB_TICKS(2)
    ) uut (
        .MCLK(mclk), .RST_B(rst_b), .HALT(halt), .HIGH_CLOCK_SELECT(high_sel),
        .CLOCK_DIVIDER_SELECT(div_sel), .FAST_WAKE_ENABLE(fast_wake),
        .IDLE_ON_HALT(idle_halt), .SYSCLK_KEEP_IN_IDLE(keep_clk),
        .WDT_ENABLE(wdt_en), .LVD_ENABLE(lvd_en), .HIGH_OSC_IS_XTAL(high_xtal),
        .LOW_OSC_IS_XTAL(low_xtal), .HIGH_OSC_TICK(high_tick),
        .LOW_OSC_TICK(low_tick), .WAKE_PIN_FALL(pin_fall), .WAKE_IRQ(irq),
        .WDT_OVERFLOW(wdt_ovf), .CLEAR_WDT_CMD(clr_wdt), .HIGH_OSC_ON(high_on),
        .LOW_OSC_ON(low_on), .SYSCLK_SEL_HIGH(sel_high),
        .SYSCLK_SEL_LOW(sel_low), .SYSCLK_DIV(sysclk_div),
        .DIV_CLKS_ON(div_clks), .TIMEBASE_CLK_ON(tb_clk), .CPU_RUN(cpu_run),
        .WDT_RUN(wdt_run), .WDT_CLEAR(wdt_clr), .HIGH_OSC_READY(high_rdy),
        .LOW_OSC_READY(low_rdy), .POWER_DOWN_FLAG(pd_flag),
        .WATCHDOG_TIMEOUT_FLAG(wdt_flag), .SYSTEM_MODE_VIEW(mode_view)
    );

    pmc_osc_model u_osc (
        .mclk(mclk), .rst_b(rst_b), .slow(slow), .high_on(high_on),
        .low_on(low_on), .high_tick(high_tick), .low_tick(low_tick)
    );

    // 10 MHz system clock
    initial
    begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    // verdict and end of run
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // shared tally for the halt entry, ready at resume and divider code comparisons
    task automatic tally(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    task automatic cmp_halt(input logic [7:0] exp);
        tally("halt entry", exp, {pd_flag, wdt_flag, wdt_clr, tb_clk,
              low_on, wdt_run, mode_view[4], mode_view[1]});
    endtask

    task automatic cmp_wake(input logic exp);
        tally("ready at resume", {7'h00, exp}, {7'h00, high_rdy});
    endtask

    task automatic cmp_div(input logic [2:0] exp);
        tally("divider code", {5'h00, exp}, {5'h00, sysclk_div});
    endtask

    // bounded wait: 0 core runs, 1 low gated, 2 high gated, 3 high not ready
    task automatic wait_for(input int what, input int lim);
        int   n;
        logic hit;
        n   = 0;
        hit = 1'h0;
        while (!hit)
        begin
            @(negedge mclk);
            case (what)
                0: hit = (cpu_run === 1'h1);
                1: hit = (sel_low === 1'h1);
                2: hit = (sel_high === 1'h1);
                default: hit = (high_rdy === 1'h0);
            endcase
            n++;
            if (!hit && n >= lim)
            begin
                $display("wrong value wait %0d expected 1 seen 0", what);
                error_cnt++;
                complete_run();
            end
        end
    endtask

    // result watcher: each result is matched with the oldest note
    initial
    begin
        logic run_d;
        logic sel_d;
        run_d = 1'h1;
        sel_d = 1'h1;
        forever
        begin
            @(posedge mclk);
            #20;
            if (run_d === 1'h1 && cpu_run === 1'h0 && halt_q.size() > 0)
                cmp_halt(halt_q.pop_front());
            if (run_d === 1'h0 && cpu_run === 1'h1 && wake_q.size() > 0)
                cmp_wake(wake_q.pop_front());
            if (sel_d === 1'h0 && sel_high === 1'h1 && div_q.size() > 0)
                cmp_div(div_q.pop_front());
            run_d = cpu_run;
            sel_d = sel_high;
        end
    end

    // halt into one power state, refused halt, then wake by a random source
    task automatic run_scn(input logic [6:0] s);
        logic deep;
        int   src;
        deep = !s[6] && !s[4] && !s[3];
        src  = $urandom % (s[4] ? 3 : 2);
        @(negedge mclk);
        {idle_halt, keep_clk, wdt_en, lvd_en, fast_wake, high_xtal} <= s[6:1];
        slow    <= 1'($urandom % 2);
        wdt_ovf <= 1'h1;
        @(negedge mclk);
        wdt_ovf <= 1'h0;
        halt_q.push_back({3'h5, s[6], !deep, s[4] && !deep, s[2], s[6]});
        halt    <= 1'h1;
        @(negedge mclk);
        halt    <= 1'h0;
        repeat (3 + $urandom % 6) @(negedge mclk);
        halt    <= 1'h1;
        @(negedge mclk);
        halt    <= 1'h0;
        wake_q.push_back(s[0]);
        {pin_fall, irq, wdt_ovf} <= 3'h4 >> src; // overflow only with wdt on
        @(negedge mclk);
        {pin_fall, irq, wdt_ovf} <= 3'h0;
        wait_for(0, 400);
        wait_for(2, 400);
        clr_wdt <= 1'h1;
        @(negedge mclk);
        clr_wdt <= 1'h0;
    endtask

    // full speed to slow and back through a random divided code
    task automatic switch_modes();
        logic [2:0] code;
        code = 3'h2 + 3'($urandom % 6);
        @(negedge mclk);
        high_sel <= 1'h0;
        div_sel  <= PMC_DIV_LOW_MAX & 3'($urandom);
        wait_for(1, 400);
        wait_for(3, 400);
        div_q.push_back(code);
        div_sel  <= code;
        wait_for(2, 400);
        high_sel <= 1'h1;
        div_sel  <= 3'h0;
        repeat (4) @(negedge mclk);
    endtask

    // main sequence
    initial
    begin
        void'($urandom(6159));
        {halt, div_sel, fast_wake, keep_clk, lvd_en, clr_wdt} = '0;
        {pin_fall, irq, wdt_ovf, slow} = '0;
        {high_sel, idle_halt, wdt_en, high_xtal} = 4'hF;
        low_xtal = 1'($urandom % 2);
        rst_b    = 1'h0;
        repeat (10) @(negedge mclk);
        rst_b <= 1'h1;
        wait_for(2, 400);
        for (int i = 0; i < 7; i++)
            run_scn(SCN[i]);
        repeat (2) switch_modes();
        if (halt_q.size() + wake_q.size() + div_q.size() != 0)
        begin
            $display("wrong value results expected 0 seen missing");
            error_cnt++;
        end
        complete_run();
    end
endmodule // pmc_clock_switch_tb_top
